// ### rtl/ddr_lane_mask_pkg.sv
// Shared constants and types for the byte-lane masked burst writer
package ddr_lane_mask_pkg;

  // ==========================================================
  // Organisation
  localparam int LANE_BITS = 9;
  localparam int LANES_NARROW = 2;
  localparam int LANES_WIDE = 4;
  localparam int BURST_WORDS = 2;
  localparam int BUF_DEPTH = 2;
  localparam int ADDR_WIDTH_DEFAULT = 4;

  // ==========================================================
  // Reset values
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic HEAD_RESET = 1'h0;

  // Gray-coded along idle -> first half -> second half
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_FIRST = 2'h1,
    PH_SECOND = 2'h3
  } phase_t;

endpackage : ddr_lane_mask_pkg

// ### rtl/ddr_byte_lane_writer.sv
// Burst-of-two write path with per-lane active-low write selects
// Function
// - Data half-words follow accepted command edge
// - Narrow: both selects low writes all bits
// - Narrow: lane zero only writes low bits
// - Narrow: lane one only writes high bits
// - Narrow: no selects low keeps contents
// - Wide: all four selects low writes all
// - Wide: lane zero alone writes bits eight-zero
// - Wide: lane one alone writes bits 17-9
// - Wide: lane two alone writes bits 26-18
// - Wide: lane three alone writes bits 35-27
// - Wide: no selects low modifies nothing
// - Each half-word uses its own select pattern
`timescale 1ns/100ps
`default_nettype none

module ddr_byte_lane_writer #(
  parameter int LANES = ddr_lane_mask_pkg::LANES_NARROW,
  parameter int ADDR_W = ddr_lane_mask_pkg::ADDR_WIDTH_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic WRITE_CMD,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [LANES*ddr_lane_mask_pkg::LANE_BITS-1:0] DATA_IN,
  input wire logic [LANES-1:0] BYTE_LANE_WRITE_SELECT_N,
  output logic WRITE_READY,
  input wire logic ARRAY_HOLD,
  input wire logic [ADDR_W-1:0] READ_ADDR,
  output logic [LANES*ddr_lane_mask_pkg::LANE_BITS-1:0] READ_DATA
);

  // ==========================================================
  // Types
  localparam int W = LANES * ddr_lane_mask_pkg::LANE_BITS;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int LB = ddr_lane_mask_pkg::LANE_BITS;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [W-1:0] data;
    logic [LANES-1:0] sel_n;
  } entry_t;

  typedef struct packed {
    ddr_lane_mask_pkg::phase_t phase;
    logic [ADDR_W-1:0] base;
    logic [1:0] count;
    logic head;
    entry_t [ddr_lane_mask_pkg::BUF_DEPTH-1:0] slot;
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0] read_data;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ==========================================================
  // Lane mask: every bit of a lane whose select is low is set
  function automatic logic [W-1:0] lane_mask(
    input logic [LANES-1:0] sel_n
  );
    logic [W-1:0] mask;
    mask = '0;
    for (int i = 0; i < LANES; i++) begin
      mask[i*LB +: LB] = {LB{~sel_n[i]}};
    end
    return mask;
  endfunction : lane_mask

  // ==========================================================
  // Lane merge: a low select takes the new lane, a high one keeps old
  function automatic logic [W-1:0] merge_lanes(
    input logic [W-1:0] old_word,
    input logic [W-1:0] new_word,
    input logic [LANES-1:0] sel_n
  );
    logic [W-1:0] take;
    logic [W-1:0] keep;
    take = lane_mask(sel_n);
    keep = ~take;
    return (old_word & keep) | (new_word & take);
  endfunction : merge_lanes

  // ==========================================================
  // Burst partner: the second half-word flips only the address LSB
  function automatic logic [ADDR_W-1:0] partner_addr(
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] flip;
    flip = '0;
    flip[0] = 1'b1;
    return base ^ flip;
  endfunction : partner_addr

  // ==========================================================
  // Command acceptance: idle and an empty buffer
  function automatic logic accepts_cmd(
    input ddr_lane_mask_pkg::phase_t phase,
    input logic [1:0] count
  );
    return (phase == ddr_lane_mask_pkg::PH_IDLE) && (count == 2'h0);
  endfunction : accepts_cmd

  // ==========================================================
  // Buffer bookkeeping
  function automatic logic [1:0] count_after(
    input logic [1:0] count,
    input logic add,
    input logic remove
  );
    logic [1:0] result;
    result = count;
    if (add && !remove) begin
      result = count + 2'h1;
    end else if (remove && !add) begin
      result = count - 2'h1;
    end
    return result;
  endfunction : count_after

  // Slot behind the oldest one, or the oldest itself when empty
  function automatic logic tail_slot(
    input logic head,
    input logic [1:0] count
  );
    return head ^ count[0];
  endfunction : tail_slot

  // ==========================================================
  // Buffer entry builder
  function automatic entry_t make_entry(
    input logic [ADDR_W-1:0] addr,
    input logic [W-1:0] data,
    input logic [LANES-1:0] sel_n
  );
    entry_t entry;
    entry.addr = addr;
    entry.data = data;
    entry.sel_n = sel_n;
    return entry;
  endfunction : make_entry

  // ==========================================================
  // Next state
  logic push;
  logic pop;
  entry_t push_entry;
  entry_t head_entry;
  logic tail;

  // ==========================================================
  // Handshake and observation outputs
  // Two free slots before a command: a stalled drain can never drop a half-word
  assign WRITE_READY = accepts_cmd(cur.phase, cur.count);
  assign READ_DATA = cur.read_data;

  // ==========================================================
  // Buffer pointers
  assign pop = (cur.count != 2'h0) && !ARRAY_HOLD;
  assign head_entry = cur.slot[cur.head];
  assign tail = tail_slot(cur.head, cur.count);

  // ==========================================================
  // State update
  always_comb begin
    next_cur = cur;
    push = 1'b0;
    push_entry = '0;
    unique case (cur.phase)
      ddr_lane_mask_pkg::PH_IDLE: begin
        if (WRITE_CMD && WRITE_READY) begin
          next_cur.base = ADDR;
          next_cur.phase = ddr_lane_mask_pkg::PH_FIRST;
        end
      end
      ddr_lane_mask_pkg::PH_FIRST: begin
        push = 1'b1;
        push_entry = make_entry(cur.base, DATA_IN, BYTE_LANE_WRITE_SELECT_N);
        next_cur.phase = ddr_lane_mask_pkg::PH_SECOND;
      end
      ddr_lane_mask_pkg::PH_SECOND: begin
        push = 1'b1;
        push_entry = make_entry(partner_addr(cur.base), DATA_IN,
          BYTE_LANE_WRITE_SELECT_N);
        next_cur.phase = ddr_lane_mask_pkg::PH_IDLE;
      end
      default: begin
        // Unused code: drop back to idle instead of locking up
        next_cur.phase = ddr_lane_mask_pkg::PH_IDLE;
      end
    endcase
    // Drain: the oldest half-word lands in the array
    if (pop) begin
      next_cur.mem[head_entry.addr] =
        merge_lanes(cur.mem[head_entry.addr], head_entry.data, head_entry.sel_n);
      next_cur.head = ~cur.head;
    end
    // Fill: the newest half-word takes the free slot
    if (push) begin
      next_cur.slot[tail] = push_entry;
    end
    next_cur.count = count_after(cur.count, push, pop);
    // Observation read, one cycle behind its address
    next_cur.read_data = cur.mem[READ_ADDR];
  end

  // ==========================================================
  // State register; array contents are undefined by reset, so cleared to zero
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cur.phase <= ddr_lane_mask_pkg::PH_IDLE;
      cur.base <= '0;
      cur.count <= ddr_lane_mask_pkg::COUNT_RESET;
      cur.head <= ddr_lane_mask_pkg::HEAD_RESET;
      cur.slot <= '0;
      cur.mem <= '0;
      cur.read_data <= '0;
    end else begin
      cur <= next_cur;
    end
  end

endmodule : ddr_byte_lane_writer

`default_nettype wire

// ### verification/lane_writer_props.sv
// Port checker for the lane writer
`timescale 1ns/100ps
`default_nettype none
module lane_writer_props #(
  parameter int W = 18,
  parameter int ADDR_W = 4
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic WRITE_CMD,
  input wire logic WRITE_READY,
  input wire logic ARRAY_HOLD,
  input wire logic [ADDR_W-1:0] READ_ADDR,
  input wire logic [W-1:0] READ_DATA
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  a_busy_after_cmd: assert property (WRITE_CMD && WRITE_READY |=> !WRITE_READY [*3])
    else $error("ready back within a burst");
  a_ready_after_drain: assert property (WRITE_CMD && WRITE_READY
    ##2 !ARRAY_HOLD ##1 !ARRAY_HOLD |=> WRITE_READY)
    else $error("ready missing after unstalled burst");
  a_stall_keeps_busy: assert property (ARRAY_HOLD && !WRITE_READY |=> !WRITE_READY)
    else $error("ready during stalled drain");
  a_idle_stays_ready: assert property (WRITE_READY && !WRITE_CMD |=> WRITE_READY)
    else $error("ready dropped without command");
  a_second_half_busy: assert property (WRITE_CMD && WRITE_READY
    ##2 ARRAY_HOLD |=> ##1 !WRITE_READY)
    else $error("ready with second half pending");
  a_read_steady: assert property ($past(WRITE_READY) && $stable(READ_ADDR)
    |=> $stable(READ_DATA))
    else $error("array changed while idle");
endmodule : lane_writer_props
bind ddr_byte_lane_writer lane_writer_props #(.W(W), .ADDR_W(ADDR_W)) u_props (
  .REF_CLK(REF_CLK), .RESET(RESET), .WRITE_CMD(WRITE_CMD), .WRITE_READY(WRITE_READY),
  .ARRAY_HOLD(ARRAY_HOLD), .READ_ADDR(READ_ADDR), .READ_DATA(READ_DATA));
`default_nettype wire

// ### verification/host_writer_model.sv
// Host controller model issuing two-word bursts
`timescale 1ns/100ps
`default_nettype none
module host_writer_model (
  input wire logic clk,
  input wire logic ready,
  output logic cmd,
  output logic [3:0] addr,
  output logic [35:0] data,
  output logic [3:0] sel_n
);
  initial {cmd, addr, data, sel_n} = 45'h0;
  task automatic burst(input logic [3:0] a, input logic [71:0] d, input logic [7:0] s);
    @(negedge clk);
    for (int n = 0; n < 99 && !ready; n++) @(negedge clk);
    cmd = 1'b1;
    addr = a;
    @(negedge clk);
    cmd = 1'b0;
    {data, sel_n} = {d[71:36], s[7:4]};
    @(negedge clk);
    {data, sel_n} = {d[35:0], s[3:0]};
    @(negedge clk);
    // Released lines must not keep the last value
    {data, sel_n} = ~{data, sel_n};
    addr = ~addr;
  endtask : burst
endmodule : host_writer_model
`default_nettype wire

// ### verification/ddr_byte_lane_writer_tb.sv
// Testbench for the lane writer, wide and narrow organisations
`timescale 1ns/100ps
`default_nettype none
module ddr_byte_lane_writer_tb;
  logic clk = 1'b0, rst = 1'b1, hold = 1'b0, look = 1'b0, cmd, rdy;
  logic [3:0] addr, sel_n, raddr = 4'h0;
  logic [35:0] data, rdata, exp_q[$], mem_ref[16] = '{default: 36'h0};
  logic [17:0] rdata_n, exp_n_q[$], mem_ref_n[16] = '{default: 18'h0};
  logic rdy_n;
  int seed = 32'h05af154c, err_total = 0, num_checks = 0;
  ddr_byte_lane_writer #(.LANES(4)) u_dut (.REF_CLK(clk), .RESET(rst), .WRITE_CMD(cmd),
    .ADDR(addr), .DATA_IN(data), .BYTE_LANE_WRITE_SELECT_N(sel_n), .WRITE_READY(rdy),
    .ARRAY_HOLD(hold), .READ_ADDR(raddr), .READ_DATA(rdata));
  ddr_byte_lane_writer #(.LANES(2)) u_dut_n (.REF_CLK(clk), .RESET(rst), .WRITE_CMD(cmd),
    .ADDR(addr), .DATA_IN(data[17:0]), .BYTE_LANE_WRITE_SELECT_N(sel_n[1:0]),
    .WRITE_READY(rdy_n), .ARRAY_HOLD(hold), .READ_ADDR(raddr), .READ_DATA(rdata_n));
  host_writer_model u_host (.clk(clk), .ready(rdy), .cmd(cmd), .addr(addr), .data(data),
    .sel_n(sel_n));
  initial forever #50 clk = ~clk;
  // Random stalls keep the buffer non-empty while bursts are refused
  always @(negedge clk) hold <= (($random(seed) & 3) == 0);
  always @(negedge clk) if (look) begin
    check("READ_DATA wide", rdata, exp_q.pop_front());
    check("READ_DATA narrow", {18'h0, rdata_n}, {18'h0, exp_n_q.pop_front()});
  end
  function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] s);
    for (int l = 0; l < 4; l++) if (!s[l]) o[l*9 +: 9] = n[l*9 +: 9];
    return o;
  endfunction : merge
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [3:0] a);
    for (int n = 0; n < 99 && !(rdy && rdy_n); n++) @(negedge clk);
    raddr = a;
    exp_q.push_back(mem_ref[a]);
    exp_n_q.push_back(mem_ref_n[a]);
    @(negedge clk);
    look <= 1'b1;
    @(negedge clk);
    look <= 1'b0;
  endtask : rd
  task automatic conclude;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // ==========================================================
  // Every select code once, then random ones
  initial begin
    logic [3:0] a, s;
    logic [35:0] d0, d1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 32; i++) begin
      a = 4'($random(seed));
      d0 = 36'({$random(seed), $random(seed)});
      d1 = 36'({$random(seed), $random(seed)});
      s = (i < 16) ? 4'(i) : 4'($random(seed));
      u_host.burst(a, {d0, d1}, {s, ~s});
      mem_ref[a] = merge(mem_ref[a], d0, s);
      mem_ref[a ^ 4'h1] = merge(mem_ref[a ^ 4'h1], d1, ~s);
      mem_ref_n[a] = 18'(merge({18'h0, mem_ref_n[a]}, d0, {2'b11, s[1:0]}));
      mem_ref_n[a ^ 4'h1] = 18'(merge({18'h0, mem_ref_n[a ^ 4'h1]}, d1, {2'b11, ~s[1:0]}));
      rd(a);
      rd(a ^ 4'h1);
    end
    conclude();
  end
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
endmodule : ddr_byte_lane_writer_tb
`default_nettype wire
